// File: design/plm_pkg.sv
// Constants, limits and encodings for the process load monitor.
// Assumes one 25 MHz control clock; all measurements arrive on it.
package plm_pkg;

    // Clock rate and the one-second base of all delays
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;
    localparam logic [5:0]  SEC_PER_MIN   = 6'h3C;

    // Widths of settings and measurements
    localparam int unsigned FW = 16;   // Frequency in 0.1 Hz steps
    localparam int unsigned PW = 8;    // Percent of rated value
    localparam int unsigned DW = 7;    // Delay in seconds
    localparam int unsigned MW = 3;    // Restart block in minutes
    localparam int unsigned WN = 16;   // Number of warning sources
    localparam int unsigned GN = 5;    // Number of warning groups

    // Setting limits and reset values
    localparam logic [DW-1:0] DELAY_MAX     = 7'h64;     // 100 s
    localparam logic [DW-1:0] DELAY_RST     = 7'h00;     // 0 s
    localparam logic [PW-1:0] UL_NOM_MIN    = 8'h14;     // 20 %
    localparam logic [PW-1:0] UL_NOM_MAX    = 8'h64;     // 100 %
    localparam logic [PW-1:0] UL_NOM_RST    = 8'h3C;     // 60 %
    localparam logic [PW-1:0] UL_ZERO_RST   = 8'h00;     // 0 %
    localparam logic [FW-1:0] FREQ_MAX      = 16'h1388;  // 500.0 Hz
    localparam logic [FW-1:0] UL_FMIN_RST   = 16'h0000;  // 0.0 Hz
    localparam logic [FW-1:0] HYST_MIN      = 16'h0003;  // 0.3 Hz
    localparam logic [FW-1:0] HYST_RST      = 16'h0003;  // 0.3 Hz
    localparam logic [PW-1:0] OL_THR_MIN    = 8'h46;     // 70 %
    localparam logic [PW-1:0] OL_THR_MAX    = 8'h96;     // 150 %
    localparam logic [PW-1:0] OL_THR_RST    = 8'h6E;     // 110 %
    localparam logic [MW-1:0] RESTART_MAX   = 3'h6;      // 6 min
    localparam logic [MW-1:0] RESTART_RST   = 3'h0;      // 0 min
    localparam logic [7:0]    RESTART_MARGIN = 8'h01;    // 1 min

    // Stop response selection
    typedef enum logic [1:0] {
        PLM_RESP_IGNORE = 2'b00,
        PLM_RESP_FREE   = 2'b01,
        PLM_RESP_RAMP   = 2'b10,
        PLM_RESP_FAST   = 2'b11
    } plm_resp_e;

    localparam plm_resp_e RESP_RST = PLM_RESP_FREE;

endpackage

// File: design/plm_persist.sv
// Persistence timer: flags a condition that held for a whole delay.
// Assumes cond and delay_s come from logic on ref_clk.
`timescale 1ns/10ps
module plm_persist #(
    parameter int unsigned TICK = plm_pkg::TICK_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  cond,
    input  wire logic [plm_pkg::DW-1:0] delay_s,
    output logic                       fired_q
);
    import plm_pkg::*;

    localparam int unsigned TW = $clog2(TICK + 1);

    logic [TW-1:0] sub_q;   // Cycles within the current second
    logic [DW-1:0] sec_q;   // Whole seconds the condition has held

    // Count while the condition holds; any drop starts over
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !cond || delay_s == DELAY_RST) begin
            sub_q   <= '0;
            sec_q   <= '0;
            fired_q <= 1'b0;
        end else if (!fired_q) begin
            if (sub_q == TW'(TICK - 1)) begin
                sub_q <= '0;
                sec_q <= sec_q + 1'b1;
                if (sec_q + 1'b1 >= delay_s) begin
                    fired_q <= 1'b1;
                end
            end else begin
                sub_q <= sub_q + 1'b1;
            end
        end
    end

    a_fire_needs_cond: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(fired_q) |-> $past(cond) && $past(sub_q) == TW'(TICK - 1))
        else $error("timer fired without a full held second");

    a_drop_clears_fire: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(cond) |=> !fired_q && sec_q == '0)
        else $error("timer kept state after condition dropped");

endmodule

// File: design/plm_monitor.sv
// Process load monitor: underload, overload, stop response, restart
// spacing, autotune response and warning groups.
// Assumes all inputs come from logic on ref_clk; frequencies in
// 0.1 Hz steps, torque and current in percent of rated.
`timescale 1ns/10ps
module plm_monitor #(
    parameter int unsigned TICK_CYCLES = plm_pkg::TICK_CYCLES
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic [plm_pkg::FW-1:0]      freq_ref,
    input  wire logic [plm_pkg::FW-1:0]      freq_mot,
    input  wire logic [plm_pkg::FW-1:0]      freq_rated,
    input  wire logic [plm_pkg::PW-1:0]      torque_pct,
    input  wire logic [plm_pkg::PW-1:0]      current_pct,
    input  wire logic [plm_pkg::PW-1:0]      cur_limit_pct,
    input  wire logic                        in_cur_limit,
    input  wire logic [plm_pkg::DW-1:0]      ul_delay_s,
    input  wire logic [plm_pkg::PW-1:0]      ul_nom_thr_pct,
    input  wire logic [plm_pkg::PW-1:0]      ul_zero_thr_pct,
    input  wire logic [plm_pkg::FW-1:0]      ul_min_freq,
    input  wire logic [plm_pkg::FW-1:0]      hyst_freq,
    input  wire logic [1:0]                  ul_resp,
    input  wire logic [plm_pkg::MW-1:0]      ul_restart_min,
    input  wire logic [plm_pkg::DW-1:0]      ol_delay_s,
    input  wire logic [plm_pkg::PW-1:0]      ol_thr_pct,
    input  wire logic [1:0]                  ol_resp,
    input  wire logic [plm_pkg::MW-1:0]      ol_restart_min,
    input  wire logic [7:0]                  fault_reset_min,
    input  wire logic                        tune_err,
    input  wire logic                        tune_resp_free,
    input  wire logic                        fault_clear,
    input  wire logic [plm_pkg::WN-1:0]      warn_in,
    input  wire logic [plm_pkg::WN-1:0]      grp1_sel,
    input  wire logic [plm_pkg::WN-1:0]      grp2_sel,
    input  wire logic [plm_pkg::WN-1:0]      grp3_sel,
    input  wire logic [plm_pkg::WN-1:0]      grp4_sel,
    input  wire logic [plm_pkg::WN-1:0]      grp5_sel,
    output logic                             steady_q,
    output logic                             ul_detect_q,
    output logic                             ol_detect_q,
    output logic                             stop_free_q,
    output logic                             stop_ramp_q,
    output logic                             stop_fast_q,
    output logic                             restart_ok_q,
    output logic [plm_pkg::GN-1:0]           warn_grp_q
);
    import plm_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    // Settings after clamping to their legal ranges
    logic [DW-1:0] ul_dly;        // Underload delay
    logic [DW-1:0] ol_dly;        // Overload delay
    logic [PW-1:0] nom_thr;       // Nominal-speed torque threshold
    logic [PW-1:0] zero_thr;      // Zero-speed torque threshold
    logic [FW-1:0] fmin;          // Minimum detection frequency
    logic [FW-1:0] hyst;          // Steady-state hysteresis
    logic [PW-1:0] ol_thr;        // Overload current threshold
    logic [MW-1:0] ul_rmin;       // Underload restart block
    logic [MW-1:0] ol_rmin;       // Overload restart block

    // Clamp each setting into its documented span
    always_comb begin
        ul_dly   = (ul_delay_s > DELAY_MAX) ? DELAY_MAX : ul_delay_s;
        ol_dly   = (ol_delay_s > DELAY_MAX) ? DELAY_MAX : ol_delay_s;
        nom_thr  = (ul_nom_thr_pct < UL_NOM_MIN) ? UL_NOM_MIN :
                   (ul_nom_thr_pct > UL_NOM_MAX) ? UL_NOM_MAX : ul_nom_thr_pct;
        zero_thr = (ul_zero_thr_pct > nom_thr) ? nom_thr : ul_zero_thr_pct;
        fmin     = (ul_min_freq > FREQ_MAX) ? FREQ_MAX : ul_min_freq;
        hyst     = (hyst_freq < HYST_MIN) ? HYST_MIN :
                   (hyst_freq > FREQ_MAX) ? FREQ_MAX : hyst_freq;
        ol_thr   = (ol_thr_pct < OL_THR_MIN) ? OL_THR_MIN :
                   (ol_thr_pct > OL_THR_MAX) ? OL_THR_MAX : ol_thr_pct;
        ul_rmin  = (ul_restart_min > RESTART_MAX) ? RESTART_MAX : ul_restart_min;
        ol_rmin  = (ol_restart_min > RESTART_MAX) ? RESTART_MAX : ol_restart_min;
    end

    // Steady-state and load conditions
    logic [FW-1:0] freq_diff;     // Absolute reference-to-motor offset
    logic          steady;        // Offset below hysteresis
    logic [31:0]   f_sq;          // Motor frequency squared
    logic [31:0]   fr_sq;         // Rated frequency squared
    logic [39:0]   lhs;           // Torque scaled by rated squared
    logic [40:0]   rhs;           // Threshold scaled by rated squared
    logic          ul_cond;       // Raw underload condition
    logic          ol_cond;       // Raw overload condition
    logic          ul_cond_q;     // Registered underload condition
    logic          ol_cond_q;     // Registered overload condition

    // Compare torque against the quadratic curve without a divider
    always_comb begin
        freq_diff = (freq_ref > freq_mot) ? freq_ref - freq_mot : freq_mot - freq_ref;
        steady    = freq_diff < hyst;
        f_sq      = freq_mot * freq_mot;
        fr_sq     = freq_rated * freq_rated;
        lhs       = 40'(torque_pct) * 40'(fr_sq);
        if (freq_mot >= freq_rated) begin
            // Above rated frequency the curve stays at the nominal value
            rhs = 41'(nom_thr) * 41'(fr_sq);
        end else begin
            rhs = 41'(zero_thr) * 41'(fr_sq)
                + 41'(nom_thr - zero_thr) * 41'(f_sq);
        end
        ul_cond = (ul_dly != DELAY_RST) && steady && (freq_mot >= fmin)
                  && (41'(lhs) < rhs);
        // Current path counts only while threshold sits below the limit
        ol_cond = (ol_dly != DELAY_RST)
                  && (in_cur_limit
                      || (steady && current_pct > ol_thr && ol_thr < cur_limit_pct));
    end

    // Register conditions and the steady flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ul_cond_q <= 1'b0;
            ol_cond_q <= 1'b0;
            steady_q  <= 1'b0;
        end else begin
            ul_cond_q <= ul_cond;
            ol_cond_q <= ol_cond;
            steady_q  <= steady;
        end
    end

    // Persistence timers, one per detector
    plm_persist #(.TICK(TICK_CYCLES)) u_ul_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (ul_cond_q),
        .delay_s (ul_dly),
        .fired_q (ul_detect_q)
    );

    plm_persist #(.TICK(TICK_CYCLES)) u_ol_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (ol_cond_q),
        .delay_s (ol_dly),
        .fired_q (ol_detect_q)
    );

    // Detection edges and latched faults
    logic ul_det_d1_q;            // Previous underload detect
    logic ol_det_d1_q;            // Previous overload detect
    logic ul_rise;                // New underload detection
    logic ol_rise;                // New overload detection
    logic ul_fault_q;             // Underload stop latched
    logic ol_fault_q;             // Overload stop latched
    logic tune_fault_q;           // Autotune stop latched

    assign ul_rise = ul_detect_q && !ul_det_d1_q;
    assign ol_rise = ol_detect_q && !ol_det_d1_q;

    // Latch stop-causing events; a new event wins over a clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ul_det_d1_q  <= 1'b0;
            ol_det_d1_q  <= 1'b0;
            ul_fault_q   <= 1'b0;
            ol_fault_q   <= 1'b0;
            tune_fault_q <= 1'b0;
        end else begin
            ul_det_d1_q <= ul_detect_q;
            ol_det_d1_q <= ol_detect_q;
            // Ignore selection never latches a stop
            if (ul_rise && plm_resp_e'(ul_resp) != PLM_RESP_IGNORE) begin
                ul_fault_q <= 1'b1;
            end else if (fault_clear) begin
                ul_fault_q <= 1'b0;
            end
            if (ol_rise && plm_resp_e'(ol_resp) != PLM_RESP_IGNORE) begin
                ol_fault_q <= 1'b1;
            end else if (fault_clear) begin
                ol_fault_q <= 1'b0;
            end
            if (tune_err && tune_resp_free) begin
                tune_fault_q <= 1'b1;
            end else if (fault_clear) begin
                tune_fault_q <= 1'b0;
            end
        end
    end

    // Stop request selection from latched faults
    logic want_free;              // Some fault asks for freewheel
    logic want_fast;              // Some fault asks for fast stop
    logic want_ramp;              // Some fault asks for ramp stop

    // Freewheel beats fast stop, fast stop beats ramp
    always_comb begin
        want_free = tune_fault_q
                  || (ul_fault_q && plm_resp_e'(ul_resp) == PLM_RESP_FREE)
                  || (ol_fault_q && plm_resp_e'(ol_resp) == PLM_RESP_FREE);
        want_fast = (ul_fault_q && plm_resp_e'(ul_resp) == PLM_RESP_FAST)
                  || (ol_fault_q && plm_resp_e'(ol_resp) == PLM_RESP_FAST);
        want_ramp = (ul_fault_q && plm_resp_e'(ul_resp) == PLM_RESP_RAMP)
                  || (ol_fault_q && plm_resp_e'(ol_resp) == PLM_RESP_RAMP);
    end

    // Drive one stop request at a time
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stop_free_q <= 1'b0;
            stop_fast_q <= 1'b0;
            stop_ramp_q <= 1'b0;
        end else begin
            stop_free_q <= want_free;
            stop_fast_q <= want_fast && !want_free;
            stop_ramp_q <= want_ramp && !want_free && !want_fast;
        end
    end

    // Minute base for restart spacing
    logic [TW-1:0] sub_q;         // Cycles within the second
    logic [5:0]    sec_q;         // Seconds within the minute
    logic          min_tick;      // One cycle per minute

    assign min_tick = (sub_q == TW'(TICK_CYCLES - 1)) && (sec_q == SEC_PER_MIN - 6'h01);

    // Free-running second and minute counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sub_q <= '0;
            sec_q <= '0;
        end else if (sub_q == TW'(TICK_CYCLES - 1)) begin
            sub_q <= '0;
            sec_q <= (sec_q == SEC_PER_MIN - 6'h01) ? 6'h00 : sec_q + 6'h01;
        end else begin
            sub_q <= sub_q + 1'b1;
        end
    end

    // Restart block counters in minutes
    logic [MW:0] ul_blk_q;        // Underload block minutes left
    logic [MW:0] ol_blk_q;        // Overload block minutes left

    // Load on detection; the partial first minute adds one so the wait is full
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ul_blk_q <= '0;
            ol_blk_q <= '0;
        end else begin
            if (ul_rise && ul_rmin != RESTART_RST) begin
                ul_blk_q <= {1'b0, ul_rmin} + 1'b1;
            end else if (min_tick && ul_blk_q != '0) begin
                ul_blk_q <= ul_blk_q - 1'b1;
            end
            if (ol_rise && ol_rmin != RESTART_RST) begin
                ol_blk_q <= {1'b0, ol_rmin} + 1'b1;
            end else if (min_tick && ol_blk_q != '0) begin
                ol_blk_q <= ol_blk_q - 1'b1;
            end
        end
    end

    // Restart permission: blocks run out and reset time leaves the margin
    logic ul_margin_ok;           // Reset time beats underload block
    logic ol_margin_ok;           // Reset time beats overload block

    always_comb begin
        ul_margin_ok = plm_resp_e'(ul_resp) == PLM_RESP_IGNORE
                     || fault_reset_min >= 8'(ul_rmin) + RESTART_MARGIN;
        ol_margin_ok = plm_resp_e'(ol_resp) == PLM_RESP_IGNORE
                     || fault_reset_min >= 8'(ol_rmin) + RESTART_MARGIN;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            restart_ok_q <= 1'b0;
        end else begin
            restart_ok_q <= ul_blk_q == '0 && ol_blk_q == '0
                         && ul_margin_ok && ol_margin_ok;
        end
    end

    // Warning groups: OR of the selected active warnings
    logic [WN-1:0] grp_sel [GN];  // Selection masks per group

    assign grp_sel[0] = grp1_sel;
    assign grp_sel[1] = grp2_sel;
    assign grp_sel[2] = grp3_sel;
    assign grp_sel[3] = grp4_sel;
    assign grp_sel[4] = grp5_sel;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            warn_grp_q <= '0;
        end else begin
            for (int g = 0; g < GN; g++) begin
                warn_grp_q[g] <= |(warn_in & grp_sel[g]);
            end
        end
    end

    // Checks kept beside the logic
    sequence s_ul_raise;
        !ul_detect_q ##1 ul_detect_q;
    endsequence

    a_ul_needs_cond: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_ul_raise |-> $past(ul_cond_q) && ul_dly != DELAY_RST)
        else $error("underload raised without its condition");

    a_low_freq_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        freq_mot < fmin |=> !ul_cond_q)
        else $error("underload condition below minimum frequency");

    a_steady_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        freq_diff >= hyst |=> !steady_q)
        else $error("steady flag set with large offset");

    a_climit_monitors: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_cur_limit && ol_dly != DELAY_RST |=> ol_cond_q)
        else $error("current limit did not arm overload");

    a_zero_delay_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ol_dly == DELAY_RST |=> ##1 !ol_detect_q)
        else $error("overload detected with zero delay");

    a_ul_stop_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ul_rise && plm_resp_e'(ul_resp) == PLM_RESP_FREE && !fault_clear
        ##1 plm_resp_e'(ul_resp) == PLM_RESP_FREE |=> stop_free_q)
        else $error("underload freewheel not requested");

    a_ol_ignore_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ol_rise && plm_resp_e'(ol_resp) == PLM_RESP_IGNORE && !ol_fault_q |=> !ol_fault_q)
        else $error("ignored overload latched a stop");

    a_tune_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tune_err && tune_resp_free |=> ##1 stop_free_q)
        else $error("autotune error did not freewheel");

    a_restart_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ul_rise && ul_rmin != RESTART_RST |=> ##1 !restart_ok_q)
        else $error("restart allowed inside block time");

    a_group_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        |(warn_in & grp1_sel) |=> warn_grp_q[0])
        else $error("warning group one not raised");

endmodule

// File: tb/plm_tb.sv
// Self-checking bench for the process load monitor.
// Assumes TICK_CYCLES cut to 2, so one second of delay is two clocks.
`timescale 1ns/10ps
module tb;
    import plm_pkg::*;
    localparam int unsigned T = 2;
    logic ref_clk, rst_n, in_cur_limit, tune_err, tune_resp_free, fault_clear;
    logic [FW-1:0] freq_ref, freq_mot, freq_rated, ul_min_freq, hyst_freq;
    logic [PW-1:0] torque_pct, current_pct, cur_limit_pct, ul_nom_thr_pct;
    logic [PW-1:0] ul_zero_thr_pct, ol_thr_pct;
    logic [DW-1:0] ul_delay_s, ol_delay_s;
    logic [MW-1:0] ul_restart_min, ol_restart_min;
    logic [1:0]    ul_resp, ol_resp;
    logic [7:0]    fault_reset_min;
    logic [WN-1:0] warn_in, grp1_sel, grp2_sel, grp3_sel, grp4_sel, grp5_sel;
    logic steady_q, ul_detect_q, ol_detect_q, stop_free_q, stop_ramp_q, stop_fast_q;
    logic          restart_ok_q;
    logic [GN-1:0] warn_grp_q;
    int            miscompares;   // Failed comparisons
    int            checked;       // All comparisons
    wire [2:0]     stops = {stop_free_q, stop_ramp_q, stop_fast_q};
    wire [1:0]     dets  = {ol_detect_q, ul_detect_q};
    // Row: reference, motor frequency, warnings, expected steady and groups
    typedef struct packed { logic [15:0] fr, fm, w; logic st; logic [4:0] g; } plm_row_s;
    plm_row_s rows [4] = '{
        '{16'h0064, 16'h0064, 16'h0001, 1'h1, 5'h01},
        '{16'h0064, 16'h0061, 16'h0002, 1'h0, 5'h02},
        '{16'h0061, 16'h0064, 16'h0000, 1'h0, 5'h00},
        '{16'h0064, 16'h0066, 16'h0084, 1'h1, 5'h14}};

    plm_monitor #(.TICK_CYCLES(T)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .freq_ref(freq_ref), .freq_mot(freq_mot),
        .freq_rated(freq_rated), .torque_pct(torque_pct), .current_pct(current_pct),
        .cur_limit_pct(cur_limit_pct), .in_cur_limit(in_cur_limit), .ul_delay_s(ul_delay_s),
        .ul_nom_thr_pct(ul_nom_thr_pct), .ul_zero_thr_pct(ul_zero_thr_pct),
        .ul_min_freq(ul_min_freq), .hyst_freq(hyst_freq), .ul_resp(ul_resp),
        .ul_restart_min(ul_restart_min), .ol_delay_s(ol_delay_s), .ol_thr_pct(ol_thr_pct),
        .ol_resp(ol_resp), .ol_restart_min(ol_restart_min), .fault_reset_min(fault_reset_min),
        .tune_err(tune_err), .tune_resp_free(tune_resp_free), .fault_clear(fault_clear),
        .warn_in(warn_in), .grp1_sel(grp1_sel), .grp2_sel(grp2_sel), .grp3_sel(grp3_sel),
        .grp4_sel(grp4_sel), .grp5_sel(grp5_sel), .steady_q(steady_q),
        .ul_detect_q(ul_detect_q), .ol_detect_q(ol_detect_q), .stop_free_q(stop_free_q),
        .stop_ramp_q(stop_ramp_q), .stop_fast_q(stop_fast_q), .restart_ok_q(restart_ok_q),
        .warn_grp_q(warn_grp_q));

    // Free-running 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Compares one value and counts the outcome
    task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask

    // Prints the counts and the verdict, then stops
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Bounded wait for a detector output; a timeout ends the run
    task automatic wait_det(int b);
        for (int i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            #1;
            if (dets[b] === 1'b1) return;
        end
        cmp("detect wait", 16'h0001, 16'h0000);
        wrap_up();
    endtask

    // Lets n edges pass, then settles past the edge
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        miscompares = 0;
        checked = 0;
        {rst_n, in_cur_limit, tune_err, tune_resp_free, fault_clear} = 5'h00;
        {freq_ref, freq_mot, freq_rated} = {16'h01F4, 16'h01F4, 16'h01F4};
        {ul_min_freq, hyst_freq, torque_pct, current_pct} = {16'h0000, 16'h0003, 8'h50, 8'h32};
        {cur_limit_pct, ul_nom_thr_pct, ul_zero_thr_pct, ol_thr_pct} = 32'h963C006E;
        {ul_delay_s, ol_delay_s, ul_restart_min, ol_restart_min} = {7'h01, 7'h00, 3'h0, 3'h0};
        {ul_resp, ol_resp, fault_reset_min, warn_in} = {2'h0, 2'h1, 8'h00, 16'h0000};
        {grp1_sel, grp2_sel, grp3_sel} = {16'h0001, 16'h0002, 16'h0004};
        {grp4_sel, grp5_sel} = {16'h0008, 16'h00F0};
        step(8);
        rst_n <= 1'b1;
        step(1);
        cmp("reset outputs", 16'h0000, {dets, stops, restart_ok_q, warn_grp_q});
        $display("test reset done");
        // Table of steady-state and warning group cases
        foreach (rows[i]) begin
            @(posedge ref_clk);
            freq_ref <= rows[i].fr;
            freq_mot <= rows[i].fm;
            warn_in <= rows[i].w;
            step(2);
            cmp("steady", rows[i].st, steady_q);
            cmp("groups", rows[i].g, warn_grp_q);
        end
        $display("test table done");
        freq_ref <= 16'h01F4;
        freq_mot <= 16'h01F4;
        // Underload with every response, then cleared
        for (int r = 0; r < 4; r++) begin
            ul_resp <= r[1:0];
            torque_pct <= 8'h0A;
            step(2);
            cmp("early underload", 16'h0000, ul_detect_q);
            wait_det(0);
            step(3);
            cmp("underload stop", (r == 0) ? 16'h0 : 16'h4 >> (r - 1), stops);
            torque_pct <= 8'h50;
            fault_clear <= 1'b1;
            step(1);
            fault_clear <= 1'b0;
            step(3);
            cmp("cleared", 16'h0000, {dets, stops});
        end
        $display("test underload done");
        // Below minimum frequency nothing is detected
        ul_min_freq <= 16'h01F5;
        torque_pct <= 8'h0A;
        step(20);
        cmp("min freq", 16'h0000, ul_detect_q);
        torque_pct <= 8'h50;
        // Current limiting out of steady state still trips overload
        ol_delay_s <= 7'h01;
        freq_ref <= 16'h0100;
        in_cur_limit <= 1'b1;
        wait_det(1);
        step(3);
        cmp("overload stop", 16'h0004, stops);
        in_cur_limit <= 1'b0;
        fault_clear <= 1'b1;
        step(1);
        fault_clear <= 1'b0;
        step(3);
        // Autotune error with freewheel selected
        tune_resp_free <= 1'b1;
        tune_err <= 1'b1;
        step(1);
        tune_err <= 1'b0;
        step(3);
        cmp("tune stop", 16'h0004, stops);
        $display("test faults done");
        // Curve at half rated speed sits at a quarter of the nominal threshold
        {freq_ref, freq_mot, ul_min_freq, torque_pct} <= {16'h00FA, 16'h00FA, 16'h0000, 8'h14};
        {fault_reset_min, ul_restart_min} <= {8'h02, 3'h1};
        step(20);
        cmp("curve above", 16'h0000, ul_detect_q);
        cmp("restart free", 16'h0001, restart_ok_q);
        torque_pct <= 8'h0A;
        wait_det(0);
        step(2);
        cmp("restart held", 16'h0000, restart_ok_q);
        step(110);
        cmp("restart early", 16'h0000, restart_ok_q);
        step(135);
        cmp("restart late", 16'h0001, restart_ok_q);
        fault_reset_min <= 8'h01;
        step(2);
        cmp("reset margin", 16'h0000, restart_ok_q);
        {fault_reset_min, ol_restart_min} <= {8'h02, 3'h2};
        step(2);
        cmp("ol margin", 16'h0000, restart_ok_q);
        ol_restart_min <= 3'h1;
        step(2);
        cmp("ol margin met", 16'h0001, restart_ok_q);
        $display("test restart done");
        // Steady overcurrent with ignore selected: detected, no stop
        {ol_resp, current_pct, fault_clear} <= {2'h0, 8'h78, 1'b1};
        step(1);
        fault_clear <= 1'b0;
        wait_det(1);
        step(3);
        cmp("ignored overload", 16'h0000, stops);
        cur_limit_pct <= 8'h6E;
        step(3);
        cmp("limit gate", 16'h0000, ol_detect_q);
        $display("test overcurrent done");
        wrap_up();
    end
endmodule
